// ===== tfd_decoder.sv
// Host-side task-file address decoder with data port byte and word steering.
// Assumes host pins are asynchronous and one card clock; status and error come from the drive core.
//
// Overview of operation
// - Output-enable low at power-up selects direct-drive.
// - Direct-drive: only I/O task file cycles respond.
// - Direct-drive data is 16-bit until set-features.
// - Hot reinsertion always comes up card ATA.
// - Direct-drive decode by byte enables and A2-A0.
// - Four mappings chosen by configuration index.
// - Any sixteen-byte I/O block works.
// - Primary/secondary decode on upper address bits.
// - Word access to register 0 ignores A0.
// - Low-byte pairs give even then odd.
// - High-byte access to 0 reaches error/features.
// - Contiguous offsets 0-7 with duplicates and E/F.
// - Offsets 8, 9, D duplicate 0 and 1.
// - Offset 9 then 8 gives odd then even.
// - Byte accesses to 8 or 0 step bytes.
// - Word accesses to 8, 9, 0 step words.
// - Contiguous mapping ignores unused address lines.
// - Wide-port indication asserted on every responding I/O address, not on memory cycles.
`timescale 1ns/10ps
module tfd_decoder (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic hot_insert,
   input wire logic low_byte_enable_n,
   input wire logic high_byte_enable_n,
   input wire logic attr_select_n,
   input wire logic io_read_strobe_n,
   input wire logic io_write_strobe_n,
   input wire logic [tfd_pkg::TFD_ADDR_W-1:0] addr,
   input wire logic [15:0] data_in,
   input wire logic [1:0] config_index,
   input wire logic [7:0] status_in,
   input wire logic [7:0] error_in,
   output logic [15:0] data_out,
   output logic data_oe_lo,
   output logic data_oe_hi,
   output logic wide_port_indication_n,
   output logic direct_drive_mode,
   output logic eight_bit_mode,
   output logic [7:0] features,
   output logic [7:0] block_count,
   output logic [7:0] block_number,
   output logic [7:0] track_low,
   output logic [7:0] track_high,
   output logic [7:0] drive_head_select,
   output logic [7:0] command_code,
   output logic command_strobe,
   output logic [7:0] device_control,
   output logic [tfd_pkg::TFD_PTR_W-1:0] buffer_ptr
);
   import tfd_pkg::*;

   logic s_oen, s_wen, s_hot, s_ce1n, s_ce2n, s_regn, s_iordn, s_iowrn;
   logic [TFD_ADDR_W-1:0] s_addr;
   logic [15:0] s_data;
   logic [1:0] strap_cnt_q;
   logic strap_done;

   tfd_sync2 #(.W(8), .RST_VAL(8'hFF)) u_sync_ctl (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin({output_enable_n, write_enable_n, ~hot_insert, low_byte_enable_n, high_byte_enable_n,
            attr_select_n, io_read_strobe_n, io_write_strobe_n}),
      .sync_q({s_oen, s_wen, s_hot, s_ce1n, s_ce2n, s_regn, s_iordn, s_iowrn})
   );

   tfd_sync2 #(.W(TFD_ADDR_W + 16), .RST_VAL('0)) u_sync_bus (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin({addr, data_in}),
      .sync_q({s_addr, s_data})
   );

   // Lane decode from the two byte enables.
   wire lane_word = ~s_ce1n & ~s_ce2n;
   wire lane_lo = ~s_ce1n & s_ce2n;
   wire lane_hi = s_ce1n & ~s_ce2n;
   wire io_rd = ~s_iordn;
   wire io_wr = ~s_iowrn;
   wire mem_rd = ~s_oen;
   wire mem_wr = ~s_wen;
   wire io_cyc = io_rd | io_wr;
   wire mem_cyc = mem_rd | mem_wr;

   // Offsets A, B and C are holes in the sixteen-byte block.
   function automatic logic off_mapped(input logic [3:0] off);
      off_mapped = (off < 4'hA) || (off > 4'hC);
   endfunction

   function automatic logic is_data_off(input logic [3:0] off);
      is_data_off = (off == TFD_OFF_DATA) || (off == TFD_OFF_DUP_EVEN) || (off == TFD_OFF_DUP_ODD);
   endfunction

   // Direct-drive decode: low enable reaches 0-7, high enable at 6h and 7h reaches Eh and Fh only.
   wire dd_hit = io_cyc & (lane_lo | (lane_hi & (s_addr[2:1] == 2'h3)));
   wire [3:0] dd_off = lane_lo ? {1'b0, s_addr[2:0]} : {3'h7, s_addr[0]};

   // Fixed primary or secondary window.
   wire [5:0] fix_base = (config_index == TFD_CFG_PRIMARY) ? TFD_PRI_BASE : TFD_SEC_BASE;
   wire [5:0] fix_ctrl = (config_index == TFD_CFG_PRIMARY) ? TFD_PRI_CTRL : TFD_SEC_CTRL;
   wire fix_base_hit = (s_addr[9:4] == fix_base) & ~s_addr[3];
   wire fix_ctrl_hit = (s_addr[9:4] == fix_ctrl) & (s_addr[3:1] == 3'h3);
   wire mem_win = s_addr[TFD_MEM_WIN_BIT];

   logic card_hit;
   logic [3:0] card_off;

   // Card ATA decode; the contiguous block looks at A3-A0 only.
   always_comb
   begin
      card_hit = 1'b0;
      card_off = s_addr[3:0];
      unique case (config_index)
         TFD_CFG_MEMORY:
         begin
            card_hit = mem_cyc & s_regn & (mem_win | off_mapped(s_addr[3:0]));
            card_off = mem_win ? {3'h4, s_addr[0]} : s_addr[3:0];
         end
         TFD_CFG_CONTIG:
            card_hit = io_cyc & ~s_regn & off_mapped(s_addr[3:0]);
         TFD_CFG_PRIMARY, TFD_CFG_SECONDARY:
         begin
            card_hit = io_cyc & ~s_regn & (fix_base_hit | fix_ctrl_hit);
            card_off = fix_base_hit ? {1'b0, s_addr[2:0]} : {3'h7, s_addr[0]};
         end
      endcase
   end

   logic mode_q, eight_bit_q;
   // Memory and attribute cycles are dropped in direct-drive, as is the configuration index.
   // Both enables high is standby in either mode, so nothing answers then.
   wire hit = strap_done & (mode_q ? dd_hit : card_hit & ~(s_ce1n & s_ce2n));
   wire card_mode = ~mode_q;
   wire hi_byte = card_mode & lane_hi;
   wire [3:0] raw_off = mode_q ? dd_off : card_off;
   // A card-mode high-byte access lands on the odd partner of the addressed offset.
   wire [3:0] eff_off = hi_byte ? (raw_off | 4'h1) : raw_off;
   wire data_word = hit & (card_mode ? lane_word & ((raw_off[3:1] == 3'h0) | (raw_off[3:1] == 3'h4))
                                     : (raw_off == TFD_OFF_DATA) & ~eight_bit_q);
   wire data_byte = hit & ~data_word & is_data_off(eff_off);
   wire odd_only = eff_off == TFD_OFF_DUP_ODD;
   wire rd_now = hit & (io_rd | (card_mode & mem_rd));
   wire strobe_now = hit & (io_cyc | (card_mode & mem_cyc));

   logic [TFD_PTR_W-1:0] ptr_q;
   wire [TFD_PTR_W-1:0] byte_addr = odd_only ? (ptr_q | 9'h001) : ptr_q;
   logic [15:0] buf_rdata;
   wire [7:0] buf_byte = byte_addr[0] ? buf_rdata[15:8] : buf_rdata[7:0];

   logic [7:0] count_q, number_q, trk_lo_q, trk_hi_q, head_q, feat_q, cmd_q, devctl_q;

   // Legacy readback: head and drive selects shown inverted, D7 left high.
   wire [7:0] drive_id = {2'h3, ~head_q[3:0], head_q[4], ~head_q[4]};

   function automatic logic [7:0] reg_byte(input logic [3:0] off, input logic [7:0] st, input logic [7:0] er,
                                           input logic [7:0] cnt, input logic [7:0] num, input logic [7:0] tl,
                                           input logic [7:0] th, input logic [7:0] hd, input logic [7:0] did);
      unique case (off)
         TFD_OFF_ERROR, TFD_OFF_ERROR_DUP: reg_byte = er;
         TFD_OFF_COUNT: reg_byte = cnt;
         TFD_OFF_NUMBER: reg_byte = num;
         TFD_OFF_TRACK_LO: reg_byte = tl;
         TFD_OFF_TRACK_HI: reg_byte = th;
         TFD_OFF_DRIVE_HEAD: reg_byte = hd;
         TFD_OFF_STATE_CMD, TFD_OFF_ALT_CTRL: reg_byte = st;
         TFD_OFF_DRIVE_ID: reg_byte = did;
         default: reg_byte = TFD_REG_RST;
      endcase
   endfunction

   wire [7:0] rb_lo = reg_byte(eff_off, status_in, error_in, count_q, number_q, trk_lo_q, trk_hi_q, head_q, drive_id);
   wire [7:0] rb_hi = reg_byte(eff_off | 4'h1, status_in, error_in, count_q, number_q, trk_lo_q, trk_hi_q,
                               head_q, drive_id);

   logic [15:0] rd_mux;
   logic oe_lo_d, oe_hi_d;

   always_comb
   begin
      rd_mux = TFD_DATA_RST;
      oe_lo_d = 1'b0;
      oe_hi_d = 1'b0;
      if (rd_now)
      begin
         if (data_word)
         begin
            rd_mux = buf_rdata;
            oe_lo_d = 1'b1;
            oe_hi_d = 1'b1;
         end
         else if (data_byte)
         begin
            rd_mux = {buf_byte, buf_byte};
            oe_lo_d = ~hi_byte;
            oe_hi_d = hi_byte;
         end
         else if (card_mode & lane_word)
         begin
            rd_mux = {rb_hi, rb_lo};
            oe_lo_d = 1'b1;
            oe_hi_d = 1'b1;
         end
         else
         begin
            rd_mux = {rb_lo, rb_lo};
            oe_lo_d = ~hi_byte;
            oe_hi_d = hi_byte;
         end
      end
   end

   // Access attributes held while the strobe is low and acted on when it ends.
   logic acc_q, acc_wr_q, acc_word_q, acc_byte_q, acc_odd_q, acc_hi_q;
   logic [3:0] acc_off_q;
   logic [15:0] acc_data_q;
   wire acc_end = acc_q & ~strobe_now;
   wire wr_end = acc_end & acc_wr_q;
   wire [7:0] wr_byte = acc_hi_q ? acc_data_q[15:8] : acc_data_q[7:0];
   wire reg_wr = wr_end & ~acc_word_q & ~acc_byte_q;
   wire cmd_wr = reg_wr & (acc_off_q == TFD_OFF_STATE_CMD);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         acc_q <= 1'b0;
         acc_wr_q <= 1'b0;
         acc_word_q <= 1'b0;
         acc_byte_q <= 1'b0;
         acc_odd_q <= 1'b0;
         acc_hi_q <= 1'b0;
         acc_off_q <= TFD_OFF_DATA;
         acc_data_q <= TFD_DATA_RST;
      end
      else
      begin
         acc_q <= strobe_now;
         if (strobe_now)
         begin
            acc_wr_q <= io_wr | (card_mode & mem_wr);
            acc_word_q <= data_word;
            acc_byte_q <= data_byte;
            acc_odd_q <= odd_only;
            acc_hi_q <= hi_byte;
            acc_off_q <= eff_off;
            acc_data_q <= s_data;
         end
      end
   end

   // Buffer word index comes from the live decode while the strobe is low, from the latch at its end.
   wire [TFD_PTR_W-1:0] wr_addr = acc_odd_q ? (ptr_q | 9'h001) : ptr_q;
   wire buf_wr_lo = wr_end & (acc_word_q | (acc_byte_q & ~wr_addr[0]));
   wire buf_wr_hi = wr_end & (acc_word_q | (acc_byte_q & wr_addr[0]));
   wire [7:0] buf_idx = acc_end ? wr_addr[8:1] : byte_addr[8:1];
   wire [15:0] buf_wdata = acc_word_q ? acc_data_q : {wr_byte, wr_byte};

   tfd_data_buffer u_buf (
      .ref_clk(ref_clk),
      .wr_lo(buf_wr_lo),
      .wr_hi(buf_wr_hi),
      .word_idx(buf_idx),
      .wdata(buf_wdata),
      .rdata(buf_rdata)
   );

   // Pointer steps only when a data-port strobe completes.
   logic [TFD_PTR_W-1:0] ptr_d;
   always_comb
   begin
      ptr_d = ptr_q;
      if (acc_end & acc_word_q)
         ptr_d = {ptr_q[8:1] + 8'h01, 1'b0};
      else if (acc_end & acc_byte_q & ~acc_odd_q)
         ptr_d = ptr_q + 9'h001;
      else if (acc_end & acc_byte_q & acc_odd_q & ptr_q[0])
         ptr_d = ptr_q + 9'h001;
      else if (cmd_wr)
         ptr_d = TFD_PTR_RST;
   end

   // Strap is sampled once, after the synchronisers have filled; it never changes until reset.
   assign strap_done = strap_cnt_q == TFD_STRAP_WAIT;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         strap_cnt_q <= 2'h0;
         mode_q <= 1'b0;
         eight_bit_q <= 1'b0;
         ptr_q <= TFD_PTR_RST;
      end
      else
      begin
         if (!strap_done)
            strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == TFD_STRAP_WAIT - 2'h1)
            mode_q <= ~s_oen & s_hot;
         if (cmd_wr && wr_byte == TFD_CMD_SET_FEATURES && feat_q == TFD_FEAT_8BIT_ON)
            eight_bit_q <= 1'b1;
         else if (cmd_wr && wr_byte == TFD_CMD_SET_FEATURES && feat_q == TFD_FEAT_8BIT_OFF)
            eight_bit_q <= 1'b0;
         ptr_q <= ptr_d;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         count_q <= TFD_REG_RST;
         number_q <= TFD_REG_RST;
         trk_lo_q <= TFD_REG_RST;
         trk_hi_q <= TFD_REG_RST;
         head_q <= TFD_REG_RST;
         feat_q <= TFD_REG_RST;
         cmd_q <= TFD_REG_RST;
         devctl_q <= TFD_REG_RST;
         command_strobe <= 1'b0;
      end
      else
      begin
         command_strobe <= cmd_wr;
         if (reg_wr)
         begin
            unique case (acc_off_q)
               TFD_OFF_ERROR, TFD_OFF_ERROR_DUP: feat_q <= wr_byte;
               TFD_OFF_COUNT: count_q <= wr_byte;
               TFD_OFF_NUMBER: number_q <= wr_byte;
               TFD_OFF_TRACK_LO: trk_lo_q <= wr_byte;
               TFD_OFF_TRACK_HI: trk_hi_q <= wr_byte;
               TFD_OFF_DRIVE_HEAD: head_q <= wr_byte;
               TFD_OFF_STATE_CMD: cmd_q <= wr_byte;
               TFD_OFF_ALT_CTRL: devctl_q <= wr_byte;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         data_out <= TFD_DATA_RST;
         data_oe_lo <= 1'b0;
         data_oe_hi <= 1'b0;
         wide_port_indication_n <= 1'b1;
      end
      else
      begin
         data_out <= rd_mux;
         data_oe_lo <= oe_lo_d;
         data_oe_hi <= oe_hi_d;
         wide_port_indication_n <= ~(hit & io_cyc);
      end
   end

   assign direct_drive_mode = mode_q;
   assign eight_bit_mode = eight_bit_q;
   assign features = feat_q;
   assign block_count = count_q;
   assign block_number = number_q;
   assign track_low = trk_lo_q;
   assign track_high = trk_hi_q;
   assign drive_head_select = head_q;
   assign command_code = cmd_q;
   assign device_control = devctl_q;
   assign buffer_ptr = ptr_q;

   property p_wide_port;
      @(posedge ref_clk) disable iff (rst) (hit & io_cyc) |=> !wide_port_indication_n;
   endproperty
   a_wide_port: assert property (p_wide_port) else $error("wide port not indicated");

   property p_mode_fixed;
      @(posedge ref_clk) disable iff (rst) strap_done |=> $stable(direct_drive_mode);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed after strap");

   property p_no_mem_direct;
      @(posedge ref_clk) disable iff (rst) (mode_q & mem_rd & ~io_rd) |=> !(data_oe_lo | data_oe_hi);
   endproperty
   a_no_mem_direct: assert property (p_no_mem_direct) else $error("memory read answered");

   property p_sixteen_default;
      @(posedge ref_clk) disable iff (rst)
         (mode_q & ~eight_bit_q & rd_now & lane_lo & (raw_off == TFD_OFF_DATA)) |=> (data_oe_lo & data_oe_hi);
   endproperty
   a_sixteen_default: assert property (p_sixteen_default) else $error("data port not 16-bit");

   property p_invalid_quiet;
      @(posedge ref_clk) disable iff (rst) (mode_q & lane_word) |=> !(data_oe_lo | data_oe_hi);
   endproperty
   a_invalid_quiet: assert property (p_invalid_quiet) else $error("bus driven with both enables low");

   property p_ptr_hold;
      @(posedge ref_clk) disable iff (rst) (acc_end & ~acc_word_q & ~acc_byte_q & ~cmd_wr) |=> $stable(ptr_q);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved on register access");

   property p_word_step;
      @(posedge ref_clk) disable iff (rst)
         (acc_end & acc_word_q) |=> (ptr_q[0] == 1'b0) && (ptr_q[8:1] == $past(ptr_q[8:1]) + 8'h01);
   endproperty
   a_word_step: assert property (p_word_step) else $error("word access did not step a word");

   property p_odd_first;
      @(posedge ref_clk) disable iff (rst) (acc_end & acc_byte_q & acc_odd_q & ~ptr_q[0]) |=> $stable(ptr_q);
   endproperty
   a_odd_first: assert property (p_odd_first) else $error("odd byte first moved pointer");

   property p_hi_error;
      @(posedge ref_clk) disable iff (rst)
         (rd_now & hi_byte & (raw_off == TFD_OFF_DATA)) |=> data_oe_hi && !data_oe_lo
            && (data_out[15:8] == $past(error_in));
   endproperty
   a_hi_error: assert property (p_hi_error) else $error("high byte of register 0 not error");

endmodule

// ===== tfd_pkg.sv
// Constants shared by the task-file address decoder and its helpers.
// Assumes one card clock and a power-on reset that covers every flip-flop except the data buffer array.
package tfd_pkg;

   // Register offsets inside the sixteen-byte task-file block.
   localparam logic [3:0] TFD_OFF_DATA = 4'h0;
   localparam logic [3:0] TFD_OFF_ERROR = 4'h1;
   localparam logic [3:0] TFD_OFF_COUNT = 4'h2;
   localparam logic [3:0] TFD_OFF_NUMBER = 4'h3;
   localparam logic [3:0] TFD_OFF_TRACK_LO = 4'h4;
   localparam logic [3:0] TFD_OFF_TRACK_HI = 4'h5;
   localparam logic [3:0] TFD_OFF_DRIVE_HEAD = 4'h6;
   localparam logic [3:0] TFD_OFF_STATE_CMD = 4'h7;
   localparam logic [3:0] TFD_OFF_DUP_EVEN = 4'h8;
   localparam logic [3:0] TFD_OFF_DUP_ODD = 4'h9;
   localparam logic [3:0] TFD_OFF_ERROR_DUP = 4'hD;
   localparam logic [3:0] TFD_OFF_ALT_CTRL = 4'hE;
   localparam logic [3:0] TFD_OFF_DRIVE_ID = 4'hF;

   // Configuration indices.
   localparam logic [1:0] TFD_CFG_MEMORY = 2'h0;
   localparam logic [1:0] TFD_CFG_CONTIG = 2'h1;
   localparam logic [1:0] TFD_CFG_PRIMARY = 2'h2;
   localparam logic [1:0] TFD_CFG_SECONDARY = 2'h3;

   // Upper address bits A9-A4 of the fixed I/O windows.
   localparam logic [5:0] TFD_PRI_BASE = 6'h1F;
   localparam logic [5:0] TFD_PRI_CTRL = 6'h3F;
   localparam logic [5:0] TFD_SEC_BASE = 6'h17;
   localparam logic [5:0] TFD_SEC_CTRL = 6'h37;

   // Address bit that opens the 400h-7FFh memory data window.
   localparam int TFD_MEM_WIN_BIT = 10;
   localparam int TFD_ADDR_W = 11;
   localparam int TFD_PTR_W = 9;
   localparam int TFD_BUF_WORDS = 256;

   localparam logic [7:0] TFD_CMD_SET_FEATURES = 8'hEF;
   localparam logic [7:0] TFD_FEAT_8BIT_ON = 8'h01;
   localparam logic [7:0] TFD_FEAT_8BIT_OFF = 8'h81;

   localparam logic [7:0] TFD_REG_RST = 8'h00;
   localparam logic [15:0] TFD_DATA_RST = 16'h0000;
   localparam logic [8:0] TFD_PTR_RST = 9'h000;

   // Cycles after reset release before the strap is sampled (synchroniser depth plus one).
   localparam logic [1:0] TFD_STRAP_WAIT = 2'h3;

endpackage

// ===== tfd_sync2.sv
// Two-stage synchroniser for host pins.
// Assumes the pins are asynchronous to ref_clk; the first stage feeds only the second.
`timescale 1ns/10ps
module tfd_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] sync_q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= pin;
         sync_q <= meta_q;
      end
   end
endmodule

// ===== tfd_data_buffer.sv
// Sector data buffer as seen from the host data port.
// Assumes the caller supplies the word index; reads are combinational.
`timescale 1ns/10ps
module tfd_data_buffer
   import tfd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [7:0] word_idx,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   logic [15:0] mem [TFD_BUF_WORDS];

   assign rdata = mem[word_idx];

   // The array has no reset: its content is undefined until the host writes it.
   always_ff @(posedge ref_clk)
   begin
      if (wr_lo)
         mem[word_idx][7:0] <= wdata[7:0];
      if (wr_hi)
         mem[word_idx][15:8] <= wdata[15:8];
   end
endmodule

// ===== tfd_host.sv
// Host bus controller model that drives the card's host pins.
// Assumes the card samples every pin through two flops on ref_clk rising edges.
`timescale 1ns/10ps
module tfd_host (
   input wire logic ref_clk,
   input wire logic [15:0] data_out,
   input wire logic data_oe_lo,
   input wire logic data_oe_hi,
   input wire logic wide_port_indication_n,
   output logic output_enable_n,
   output logic write_enable_n,
   output logic low_byte_enable_n,
   output logic high_byte_enable_n,
   output logic attr_select_n,
   output logic io_read_strobe_n,
   output logic io_write_strobe_n,
   output logic [10:0] addr,
   output logic [15:0] data_in
);
   initial
   begin
      {output_enable_n, write_enable_n, io_read_strobe_n, io_write_strobe_n} = 4'hF;
      {low_byte_enable_n, high_byte_enable_n, attr_select_n} = 3'h7;
      addr = 11'h000;
      data_in = 16'h0000;
   end
   task strap(input logic v);
      output_enable_n = v;
   endtask
   // One strobe cycle; enables, address and data stay put until the strobe has been seen high.
   // Callers never read the drive address nor repeat byte reads of offset 9.
   task acc(input logic mem, input logic rd, input logic [1:0] ce_n, input logic [10:0] a,
      input logic [15:0] wd, output logic [15:0] q, output logic [1:0] oe, output logic wn);
      @(negedge ref_clk);
      {high_byte_enable_n, low_byte_enable_n} = ce_n;
      attr_select_n = mem;
      addr = a;
      // A released bus shows the inverse of its last value, never a stale copy.
      data_in = rd ? ~data_in : wd;
      if (mem)
         {output_enable_n, write_enable_n} = {!rd, rd};
      else
         {io_read_strobe_n, io_write_strobe_n} = {!rd, rd};
      repeat (6) @(negedge ref_clk);
      q = data_out;
      oe = {data_oe_hi, data_oe_lo};
      wn = wide_port_indication_n;
      {output_enable_n, write_enable_n, io_read_strobe_n, io_write_strobe_n} = 4'hF;
      repeat (4) @(negedge ref_clk);
      {high_byte_enable_n, low_byte_enable_n} = 2'h3;
      data_in = ~data_in;
      repeat (2) @(negedge ref_clk);
   endtask
endmodule

// ===== tb_tfd_decoder.sv
// Self-checking bench for the task-file decoder, driven through the host model.
// Assumes the design carries its own timing assertions.
`timescale 1ns/10ps
module tb_tfd_decoder;
   typedef struct {logic mem; logic rd; logic [1:0] cfg; logic [1:0] ce_n; logic [10:0] a;
      logic [15:0] wd; logic [15:0] msk; logic [15:0] exp;} tfd_row_t;
   logic ref_clk, rst, hot_insert, oe_lo, oe_hi, wide_n, dd_mode, eight_bit, wn;
   logic oe_n, we_n, lo_n, hi_n, reg_n, rd_n, wr_n;
   logic [1:0] config_index, oe;
   logic [7:0] status_in, error_in;
   logic [10:0] addr;
   logic [15:0] data_in, data_out, q;
   logic [8:0] buffer_ptr;
   logic [7:0] cnt, num, feat, cmd;
   logic cmd_stb;
   int fail_count = 0;
   int n_checks = 0;
   int n_cmd = 0;
   tfd_row_t rows[11] = '{
      '{0, 0, 1, 2, 11'h7F2, 16'h005A, 16'h0000, 16'h0000},
      '{0, 1, 1, 2, 11'h002, 16'h0000, 16'h00FF, 16'h005A},
      '{0, 0, 2, 2, 11'h1F3, 16'h0033, 16'h0000, 16'h0000},
      '{0, 1, 2, 2, 11'h1F3, 16'h0000, 16'h00FF, 16'h0033},
      '{0, 1, 3, 2, 11'h173, 16'h0000, 16'h00FF, 16'h0033},
      '{1, 0, 0, 2, 11'h004, 16'h0077, 16'h0000, 16'h0000},
      '{1, 1, 0, 2, 11'h004, 16'h0000, 16'h00FF, 16'h0077},
      '{0, 1, 1, 2, 11'h00D, 16'h0000, 16'h00FF, 16'h00E5},
      '{0, 1, 1, 1, 11'h000, 16'h0000, 16'hFF00, 16'hE500},
      '{0, 1, 2, 2, 11'h3F6, 16'h0000, 16'h00FF, 16'h0050},
      '{0, 1, 1, 2, 11'h00E, 16'h0000, 16'h00FF, 16'h0050}};
   tfd_host u_tfd_host (.ref_clk(ref_clk), .data_out(data_out), .data_oe_lo(oe_lo), .data_oe_hi(oe_hi),
      .wide_port_indication_n(wide_n), .output_enable_n(oe_n), .write_enable_n(we_n),
      .low_byte_enable_n(lo_n), .high_byte_enable_n(hi_n), .attr_select_n(reg_n),
      .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n), .addr(addr), .data_in(data_in));
   tfd_decoder u_tfd_decoder (.ref_clk(ref_clk), .rst(rst), .output_enable_n(oe_n), .write_enable_n(we_n),
      .hot_insert(hot_insert), .low_byte_enable_n(lo_n), .high_byte_enable_n(hi_n), .attr_select_n(reg_n),
      .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n), .addr(addr), .data_in(data_in),
      .config_index(config_index), .status_in(status_in), .error_in(error_in), .data_out(data_out),
      .data_oe_lo(oe_lo), .data_oe_hi(oe_hi), .wide_port_indication_n(wide_n), .direct_drive_mode(dd_mode),
      .eight_bit_mode(eight_bit), .features(feat), .block_count(cnt), .block_number(num), .track_low(),
      .track_high(), .drive_head_select(), .command_code(cmd), .command_strobe(cmd_stb), .device_control(),
      .buffer_ptr(buffer_ptr));
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // The command strobe stands one cycle, so each pulse meets exactly one falling edge.
   always @(negedge ref_clk)
      if (cmd_stb === 1'b1)
         n_cmd++;
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task go(input logic mem, input logic rd, input logic [1:0] ce_n, input logic [10:0] a, input logic [15:0] wd);
      u_tfd_host.acc(mem, rd, ce_n, a, wd, q, oe, wn);
   endtask
   task boot(input logic strap_n, input logic hot);
      rst = 1'b1;
      hot_insert = hot;
      u_tfd_host.strap(strap_n);
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      // The strap must outlast the synchroniser and the sampling edge.
      repeat (8) @(negedge ref_clk);
      u_tfd_host.strap(1'b1);
      repeat (2) @(negedge ref_clk);
   endtask
   task test_done();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #400000;
      fail_count++;
      test_done();
   end
   initial
   begin
      {rst, hot_insert, config_index, status_in, error_in} = {1'b1, 1'b0, 2'h1, 8'h50, 8'hE5};
      boot(1'b1, 1'b0);
      chk({15'h0000, dd_mode}, 16'h0000);
      foreach (rows[i])
      begin
         config_index = rows[i].cfg;
         go(rows[i].mem, rows[i].rd, rows[i].ce_n, rows[i].a, rows[i].wd);
         if (rows[i].rd)
            chk(q & rows[i].msk, rows[i].exp);
         if (!rows[i].mem)
            chk({15'h0000, wn}, 16'h0000);
      end
      chk({cnt, num}, 16'h5A33);
      config_index = 2'h1;
      go(0, 0, 2'h2, 11'h007, 16'h0020);
      go(0, 0, 2'h0, 11'h001, 16'h1234);
      go(0, 0, 2'h0, 11'h008, 16'hABCD);
      chk({7'h00, buffer_ptr}, 16'h0004);
      go(0, 0, 2'h2, 11'h007, 16'h0020);
      go(0, 1, 2'h2, 11'h000, 16'h0000);
      chk({8'h00, q[7:0]}, 16'h0034);
      go(0, 1, 2'h2, 11'h000, 16'h0000);
      chk({8'h00, q[7:0]}, 16'h0012);
      go(0, 1, 2'h2, 11'h009, 16'h0000);
      chk({8'h00, q[7:0]}, 16'h00AB);
      go(0, 1, 2'h2, 11'h008, 16'h0000);
      chk({8'h00, q[7:0]}, 16'h00CD);
      go(0, 1, 2'h2, 11'h002, 16'h0000);
      chk({7'h00, buffer_ptr}, 16'h0003);
      go(0, 0, 2'h2, 11'h007, 16'h0020);
      go(0, 1, 2'h0, 11'h009, 16'h0000);
      chk(q, 16'h1234);
      go(0, 1, 2'h0, 11'h000, 16'h0000);
      chk(q, 16'hABCD);
      go(0, 1, 2'h2, 11'h00A, 16'h0000);
      chk({13'h0000, oe, wn}, 16'h0001);
      go(0, 1, 2'h3, 11'h002, 16'h0000);
      chk({13'h0000, oe, wn}, 16'h0001);
      config_index = 2'h0;
      go(1, 0, 2'h2, 11'h007, 16'h0020);
      go(1, 1, 2'h0, 11'h40A, 16'h0000);
      chk(q, 16'h1234);
      boot(1'b0, 1'b0);
      chk({14'h0000, dd_mode, eight_bit}, 16'h0002);
      go(0, 1, 2'h1, 11'h006, 16'h0000);
      chk({8'h00, q[7:0]}, 16'h0050);
      go(0, 1, 2'h0, 11'h003, 16'h0000);
      chk({13'h0000, oe, wn}, 16'h0001);
      go(1, 1, 2'h2, 11'h003, 16'h0000);
      chk({14'h0000, oe}, 16'h0000);
      go(0, 1, 2'h2, 11'h000, 16'h0000);
      chk(q, 16'h1234);
      chk({14'h0000, oe}, 16'h0003);
      go(0, 0, 2'h2, 11'h001, 16'h0001);
      go(0, 0, 2'h2, 11'h007, 16'h00EF);
      chk({15'h0000, eight_bit}, 16'h0001);
      chk({feat, cmd}, 16'h01EF);
      go(0, 1, 2'h2, 11'h000, 16'h0000);
      chk({6'h00, oe, q[7:0]}, 16'h0134);
      boot(1'b0, 1'b1);
      chk({15'h0000, dd_mode}, 16'h0000);
      chk(n_cmd[15:0], 16'h0005);
      test_done();
   end
endmodule
